// file: tsp_pkg.sv
// ----------------------------------------------------------------------------
// Overview of operation
// - Eight two-way pins, general I/O whenever no timer, PWM or host request claims them
// - In slave mode pins 3 to 5 drive host interrupt requests
// - Direction bit 1 makes the pin an output, 0 an input
// - Direction register is write only and always reads all ones
// - Reset and hardware standby clear the direction register to zero
// - Software standby keeps direction, so output pins keep driving
// - Software standby entry resets supporting modules, pins revert to general I/O
// - Data read gives latch where direction is 1, live pin where 0
// - Direction-based read select also holds for pins owned by modules
// - Reset and hardware standby clear the latch, software standby holds it
// - Pin function depends on slave mode, direction and module enables
// - Pin 7 function chosen by second PWM output enable and its direction
// - Direction at index ffb5, data at index ffb7, eight bits, reset zero
// - PWM enable 0 gives general I/O, enable 1 drives PWM waveform
// - Slave mode when host port enable is set in single-chip operation
// ----------------------------------------------------------------------------
package tsp_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_DIR = 16'hffb5;
	localparam logic [15:0] IDX_DATA = 16'hffb7;
	localparam logic [15:0] IDX_FUNC = 16'hffb8;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W = 16;

	// Reset and read-back values
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [7:0] DIR_READ = 8'hff;

	// Function register fields
	localparam int FN_HOST_EN = 0;
	localparam int FN_SINGLE_CHIP = 1;
	localparam int FN_PWM0_OE = 2;
	localparam int FN_PWM1_OE = 3;
	localparam logic [7:0] FUNC_MASK = 8'h0f;

	// Pin positions of shared functions
	localparam int PIN_T0_COUNT = 0;
	localparam int PIN_T1_COUNT = 1;
	localparam int PIN_T0_CMP = 2;
	localparam int PIN_T0_CLEAR = 3;
	localparam int PIN_T1_CMP = 4;
	localparam int PIN_T1_CLEAR = 5;
	localparam int PIN_PWM0 = 6;
	localparam int PIN_PWM1 = 7;
	localparam int PIN_IRQ_LO = 3;

endpackage

// file: tsp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module tsp_sync #(
	parameter int WIDTH = 9
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// Elaboration check: an empty bus cannot be synchronised
	if (WIDTH < 1) begin : g_bad_width
		$error("tsp_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// file: tsp_pin_mux.sv
`timescale 1ns/1ps
// Per-pin selection between module ownership and general I/O
module tsp_pin_mux #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] dir,
	input wire logic [PINS-1:0] latch,
	input wire logic [PINS-1:0] mod_own,
	input wire logic [PINS-1:0] mod_val,
	output logic [PINS-1:0] pin_drive,
	output logic [PINS-1:0] pin_level
);
	// Elaboration check: at least one pin to select for
	if (PINS < 1) begin : g_bad_pins
		$error("tsp_pin_mux: PINS must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < PINS; i++) begin : g_pin
			// Module output wins over latch and direction
			assign pin_drive[i] = mod_own[i] | dir[i];
			assign pin_level[i] = mod_own[i] ? mod_val[i] : latch[i];
		end
	endgenerate
endmodule

// file: tsp_port.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module tsp_port #(
	parameter int PINS = 8,
	parameter int AW = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic timer0_compare_output,
	input wire logic timer0_compare_en,
	input wire logic timer1_compare_output,
	input wire logic timer1_compare_en,
	input wire logic pwm0_wave_output,
	input wire logic pwm1_wave_output,
	input wire logic [2:0] host_irq,
	output logic timer0_clear_input,
	output logic timer1_clear_input,
	output logic timer0_count_input,
	output logic timer1_count_input,
	output logic slave_mode
);
	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// Pin map is fixed; the alias test needs address bits above the index
	if (PINS != 8) begin : g_bad_pins
		$error("tsp_port: pin map is fixed at eight pins");
	end
	if (AW <= tsp_pkg::IDX_W + tsp_pkg::ADDR_LSB) begin : g_bad_aw
		$error("tsp_port: AW too narrow for register indices");
	end

	logic [PINS-1:0] dir_q;
	logic [PINS-1:0] latch_q;
	logic [7:0] func_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [PINS-1:0] pin_out_q;
	logic [PINS-1:0] pin_oe_q;
	logic slave_q;
	logic sw_prev_q;
	logic [3:0] tin_q;

	logic [PINS:0] sync_w;
	logic [PINS-1:0] pin_sync;
	logic hw_stby;
	logic [PINS-1:0] mod_own;
	logic [PINS-1:0] mod_val;
	logic [PINS-1:0] drive_w;
	logic [PINS-1:0] level_w;
	logic [PINS-1:0] data_read;
	logic [tsp_pkg::IDX_W-1:0] idx;
	logic aligned;
	logic hit_dir;
	logic hit_data;
	logic hit_func;
	logic mapped;
	logic access;
	logic commit;
	logic wr_lane0;
	logic sw_entry;
	logic slave_d;

	// ------------------------------------------------------------------
	// Pin and standby synchronisation
	// ------------------------------------------------------------------
	tsp_sync #(
		.WIDTH(PINS + 1)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.async_in({hw_standby, pin_in}),
		.sync_out(sync_w)
	);

	assign pin_sync = sync_w[PINS-1:0];
	assign hw_stby = sync_w[PINS];

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign idx = paddr[tsp_pkg::ADDR_LSB +: tsp_pkg::IDX_W];
	// Upper address bits must be zero so aliases do not hit
	assign aligned = (paddr[tsp_pkg::ADDR_LSB-1:0] == '0)
		&& (paddr[AW-1:tsp_pkg::ADDR_LSB+tsp_pkg::IDX_W] == '0);
	assign hit_dir = aligned && (idx == tsp_pkg::IDX_DIR);
	assign hit_data = aligned && (idx == tsp_pkg::IDX_DATA);
	assign hit_func = aligned && (idx == tsp_pkg::IDX_FUNC);
	assign mapped = hit_dir | hit_data | hit_func;
	assign access = psel & penable;
	// Write lands only at the edge where pready is seen high
	assign commit = ce & access & pready_q & pwrite;
	assign wr_lane0 = commit & pstrb[0];

	// Access phase is two cycles: pready rises one edge after penable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else if (ce) begin
			pready_q <= access & ~pready_q;
		end
	end

	// Live pin where direction is 0, latch where 1, also for module pins
	assign data_read = (dir_q & latch_q) | (~dir_q & pin_sync);

	// Read data and error captured together with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			if (access & ~pready_q) begin
				pslverr_q <= ~mapped;
				if (pwrite || !mapped) begin
					prdata_q <= 32'h0000_0000;
				end else if (hit_dir) begin
					prdata_q <= {24'h00_0000, tsp_pkg::DIR_READ};
				end else if (hit_data) begin
					prdata_q <= {24'h00_0000, data_read};
				end else begin
					prdata_q <= {24'h00_0000, func_q};
				end
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Port registers
	// ------------------------------------------------------------------
	// Hardware standby acts as a held clear; software standby changes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q <= tsp_pkg::DIR_RESET;
		end else if (ce) begin
			if (hw_stby) begin
				dir_q <= tsp_pkg::DIR_RESET;
			end else if (wr_lane0 && hit_dir) begin
				dir_q <= pwdata[PINS-1:0];
			end
		end
	end

	// Latch is written regardless of direction or module ownership
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= tsp_pkg::DATA_RESET;
		end else if (ce) begin
			if (hw_stby) begin
				latch_q <= tsp_pkg::DATA_RESET;
			end else if (wr_lane0 && hit_data) begin
				latch_q <= pwdata[PINS-1:0];
			end
		end
	end

	assign sw_entry = sw_standby & ~sw_prev_q;

	// Standby edge detect; sw_standby is same-clock logic, no sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_prev_q <= 1'b0;
		end else if (ce) begin
			sw_prev_q <= sw_standby;
		end
	end

	// Function bits; entering standby initialises the PWM enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_q <= tsp_pkg::FUNC_RESET;
		end else if (ce) begin
			if (hw_stby) begin
				func_q <= tsp_pkg::FUNC_RESET;
			end else if (sw_entry) begin
				func_q[tsp_pkg::FN_PWM0_OE] <= 1'b0;
				func_q[tsp_pkg::FN_PWM1_OE] <= 1'b0;
			end else if (wr_lane0 && hit_func) begin
				func_q <= pwdata[7:0] & tsp_pkg::FUNC_MASK;
			end
		end
	end

	// ------------------------------------------------------------------
	// Function selection
	// ------------------------------------------------------------------
	assign slave_d = func_q[tsp_pkg::FN_HOST_EN] & func_q[tsp_pkg::FN_SINGLE_CHIP];

	// Module claims per pin; all dropped while software standby lasts
	always_comb begin
		mod_own = '0;
		mod_val = '0;
		if (!sw_standby) begin
			mod_own[tsp_pkg::PIN_T0_CMP] = timer0_compare_en;
			mod_val[tsp_pkg::PIN_T0_CMP] = timer0_compare_output;
			mod_own[tsp_pkg::PIN_T1_CMP] = timer1_compare_en;
			mod_val[tsp_pkg::PIN_T1_CMP] = timer1_compare_output;
			mod_own[tsp_pkg::PIN_PWM0] = func_q[tsp_pkg::FN_PWM0_OE];
			mod_val[tsp_pkg::PIN_PWM0] = pwm0_wave_output;
			mod_own[tsp_pkg::PIN_PWM1] = func_q[tsp_pkg::FN_PWM1_OE];
			mod_val[tsp_pkg::PIN_PWM1] = pwm1_wave_output;
			// Slave claim comes last so it overrides timer 1 compare on pin 4
			if (slave_q) begin
				mod_own[tsp_pkg::PIN_IRQ_LO +: 3] = 3'h7;
				mod_val[tsp_pkg::PIN_IRQ_LO +: 3] = host_irq;
			end
		end
	end

	tsp_pin_mux #(
		.PINS(PINS)
	) u_mux (
		.dir(dir_q),
		.latch(latch_q),
		.mod_own(mod_own),
		.mod_val(mod_val),
		.pin_drive(drive_w),
		.pin_level(level_w)
	);

	// Pins driven from flops so glitches never reach the pads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe_q <= '0;
			pin_out_q <= '0;
			slave_q <= 1'b0;
		end else if (ce) begin
			pin_oe_q <= drive_w;
			pin_out_q <= level_w;
			slave_q <= slave_d;
		end
	end

	// Timer inputs always follow the synced pins; the timers decide use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tin_q <= 4'h0;
		end else if (ce) begin
			tin_q <= {pin_sync[tsp_pkg::PIN_T1_COUNT], pin_sync[tsp_pkg::PIN_T0_COUNT],
				pin_sync[tsp_pkg::PIN_T1_CLEAR], pin_sync[tsp_pkg::PIN_T0_CLEAR]};
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign slave_mode = slave_q;
	assign timer0_clear_input = tin_q[0];
	assign timer1_clear_input = tin_q[1];
	assign timer0_count_input = tin_q[2];
	assign timer1_count_input = tin_q[3];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	// Pin flops lag the claims by one edge, so consequences look one edge on
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	dir_reads_ones_a: assert property (
		(ce && access && !pready_q && !pwrite && hit_dir) |=> (prdata_q[7:0] == 8'hff))
		else $error("direction read did not return all ones");

	dir_hw_clear_a: assert property (
		(ce && hw_stby) |=> (dir_q == 8'h00))
		else $error("direction not cleared in hardware standby");

	latch_hw_clear_a: assert property (
		(ce && hw_stby) |=> (latch_q == 8'h00))
		else $error("latch not cleared in hardware standby");

	sw_hold_a: assert property (
		(ce && sw_standby && !hw_stby && !commit) |=> ($stable(dir_q) && $stable(latch_q)))
		else $error("registers changed during software standby");

	sw_release_a: assert property (
		(ce && sw_standby && $stable(sw_standby)) |=> (pin_oe_q == $past(dir_q)))
		else $error("module kept a pin in software standby");

	data_read_mux_a: assert property (
		(ce && access && !pready_q && !pwrite && hit_data)
		|=> (prdata_q[7:0] == (($past(dir_q) & $past(latch_q)) | (~$past(dir_q) & $past(pin_sync)))))
		else $error("data read did not follow direction");

	irq_pins_a: assert property (
		(ce && slave_q && !sw_standby) |=> (pin_oe_q[5:3] == 3'h7 && pin_out_q[5:3] == $past(host_irq)))
		else $error("slave mode pins not carrying host requests");

	pwm1_drive_a: assert property (
		(ce && func_q[tsp_pkg::FN_PWM1_OE] && !sw_standby)
		|=> (pin_oe_q[7] && pin_out_q[7] == $past(pwm1_wave_output)))
		else $error("pin 7 not driving second PWM waveform");

	gpio_out_a: assert property (
		(ce && !sw_standby && !func_q[tsp_pkg::FN_PWM0_OE]) |=> (pin_oe_q[6] == $past(dir_q[6])))
		else $error("pin 6 direction mismatch in general use");

	slave_mode_a: assert property (
		ce |=> (slave_q == ($past(func_q[0]) && $past(func_q[1]))))
		else $error("slave mode does not follow control bits");

	apb_timing_a: assert property (
		(ce && psel && penable && !pready_q) ##1 (ce && psel && penable) |-> pready_q)
		else $error("pready late");

	pwm0_drive_a: assert property (
		(ce && func_q[tsp_pkg::FN_PWM0_OE] && !sw_standby)
		|=> (pin_oe_q[6] && pin_out_q[6] == $past(pwm0_wave_output)))
		else $error("pin 6 not driving first PWM waveform");

	pin_own_a: assert property (
		(ce && !sw_standby && timer1_compare_en && !slave_q)
		|=> (pin_oe_q[4] && pin_out_q[4] == $past(timer1_compare_output)))
		else $error("timer compare output did not take pin 4");

	timer_in_a: assert property (
		ce |=> (timer0_count_input == $past(pin_sync[tsp_pkg::PIN_T0_COUNT])))
		else $error("count input does not follow its pin");

	dir_write_c: cover property (commit && hit_dir && pstrb[0]);
	data_read_c: cover property (ce && access && pready_q && !pwrite && hit_data);
	sw_entry_c: cover property (ce && sw_entry && func_q[tsp_pkg::FN_PWM1_OE]);
	slave_c: cover property (slave_q && pin_oe_q[5:3] == 3'h7);
	pwm0_c: cover property (ce && func_q[tsp_pkg::FN_PWM0_OE] && !sw_standby);
endmodule

// file: tsp_pin_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// External circuitry on the port pins
// ----------------------------------------
module tsp_pin_partner #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] ext_drive,
	output logic [PINS-1:0] pin_in
);
	// Driven pins show the port's level, released pins the outside level
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drive[i];
		end
	end
endmodule

// file: timer_shared_io_port_tb_top.sv
`timescale 1ns/1ps
module timer_shared_io_port_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] ext_drive = 8'h3d;
	logic hw_standby = 1'b0;
	logic sw_standby = 1'b0;
	logic t0_cmp = 1'b0;
	logic t0_en = 1'b0;
	logic t1_cmp = 1'b0;
	logic t1_en = 1'b0;
	logic pwm0 = 1'b0;
	logic pwm1 = 1'b0;
	logic [2:0] host_irq = 3'h0;
	logic t0_clr;
	logic t1_clr;
	logic t0_cnt;
	logic t1_cnt;
	logic slave_mode;
	int mismatches = 0;
	int n_tests = 0;

	// Period of 50 ns
	always #25 pclk = ~pclk;

	tsp_port i_tsp_port (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .hw_standby(hw_standby),
		.sw_standby(sw_standby), .timer0_compare_output(t0_cmp), .timer0_compare_en(t0_en),
		.timer1_compare_output(t1_cmp), .timer1_compare_en(t1_en), .pwm0_wave_output(pwm0),
		.pwm1_wave_output(pwm1), .host_irq(host_irq), .timer0_clear_input(t0_clr),
		.timer1_clear_input(t1_clr), .timer0_count_input(t0_cnt), .timer1_count_input(t1_cnt),
		.slave_mode(slave_mode));

	tsp_pin_partner i_tsp_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
		.pin_in(pin_in));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {14'h0, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			mismatches++;
			$display("mismatch pready expected 1 seen 0");
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, d, rd, err);
		chk("write_error", 32'h0, {31'h0, err});
	endtask

	task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 8'h00, rd, err);
		chk(name, exp, rd);
		chk("read_error", 32'h0, {31'h0, err});
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset state: all inputs, reads follow the outside pins
	task automatic sc_reset();
		wait_cycles(4);
		chk("oe_reset", 32'h0, {24'h0, pin_oe});
		rdchk("dir_read", tsp_pkg::IDX_DIR, 32'hff);
		rdchk("data_pins", tsp_pkg::IDX_DATA, 32'h3d);
		chk("count0_in", 32'h1, {31'h0, t0_cnt});
		chk("count1_in", 32'h0, {31'h0, t1_cnt});
		chk("clear0_in", 32'h1, {31'h0, t0_clr});
		chk("clear1_in", 32'h1, {31'h0, t1_clr});
	endtask

	// Mixed directions: latch on outputs, live level on inputs
	task automatic sc_mixed();
		wr(tsp_pkg::IDX_DIR, 8'h0f);
		wr(tsp_pkg::IDX_DATA, 8'ha5);
		wait_cycles(4);
		chk("oe_mixed", 32'h0f, {24'h0, pin_oe});
		chk("out_mixed", 32'ha5, {24'h0, pin_out});
		rdchk("dir_wo", tsp_pkg::IDX_DIR, 32'hff);
		rdchk("data_mixed", tsp_pkg::IDX_DATA, 32'h35);
	endtask

	// Module ownership, PWM on pins 6 and 7 and slave mode on pins 3 to 5
	task automatic sc_modules();
		t0_en <= 1'b1;
		t1_en <= 1'b1;
		pwm0 <= 1'b1;
		pwm1 <= 1'b1;
		host_irq <= 3'b011;
		wr(tsp_pkg::IDX_FUNC, 8'h0c);
		wait_cycles(3);
		chk("oe_pwm0", 32'h1, {31'h0, pin_oe[6]});
		chk("out_pwm0", 32'h1, {31'h0, pin_out[6]});
		chk("oe_pwm1", 32'h1, {31'h0, pin_oe[7]});
		chk("out_pwm1", 32'h1, {31'h0, pin_out[7]});
		chk("out_cmp0", 32'h0, {31'h0, pin_out[2]});
		rdchk("data_owned", tsp_pkg::IDX_DATA, 32'he5);
		pwm1 <= 1'b0;
		wait_cycles(2);
		chk("out_pwm1_low", 32'h0, {31'h0, pin_out[7]});
		wr(tsp_pkg::IDX_FUNC, 8'h09);
		wait_cycles(3);
		chk("slave_host_only", 32'h0, {31'h0, slave_mode});
		wr(tsp_pkg::IDX_FUNC, 8'h0b);
		wait_cycles(3);
		chk("slave_on", 32'h1, {31'h0, slave_mode});
		chk("oe_irq", 32'h7, {29'h0, pin_oe[5:3]});
		chk("out_irq", 32'h3, {29'h0, pin_out[5:3]});
	endtask

	// Software standby: owners released, direction and latch kept, PWM enables cleared
	task automatic sc_sw_standby();
		sw_standby <= 1'b1;
		wait_cycles(3);
		chk("oe_swsb", 32'h0f, {24'h0, pin_oe});
		chk("out_swsb", 32'ha5, {24'h0, pin_out});
		rdchk("data_swsb", tsp_pkg::IDX_DATA, 32'h35);
		sw_standby <= 1'b0;
		wait_cycles(3);
		chk("oe7_after", 32'h0, {31'h0, pin_oe[7]});
		rdchk("func_after", tsp_pkg::IDX_FUNC, 32'h03);
	endtask

	// Hardware standby clears direction and latch
	task automatic sc_hw_standby();
		t0_en <= 1'b0;
		t1_en <= 1'b0;
		hw_standby <= 1'b1;
		wait_cycles(4);
		hw_standby <= 1'b0;
		wait_cycles(4);
		chk("oe_hwsb", 32'h0, {24'h0, pin_oe});
		rdchk("data_hwsb", tsp_pkg::IDX_DATA, 32'h3d);
		wr(tsp_pkg::IDX_DIR, 8'hff);
		rdchk("latch_hwsb", tsp_pkg::IDX_DATA, 32'h00);
	endtask

	// Clock enable low freezes state, even a hardware standby request
	task automatic sc_clock_enable();
		ce <= 1'b0;
		hw_standby <= 1'b1;
		wait_cycles(6);
		chk("oe_frozen", 32'hff, {24'h0, pin_oe});
		hw_standby <= 1'b0;
		ce <= 1'b1;
		wait_cycles(4);
		chk("oe_after_ce", 32'hff, {24'h0, pin_oe});
	endtask

	// Unmapped index next to the data register is refused
	task automatic sc_unmapped();
		logic [31:0] rd;
		logic err;
		apb(1'b0, 16'hffb6, 8'h00, rd, err);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset();
		sc_mixed();
		sc_modules();
		sc_sw_standby();
		sc_hw_standby();
		sc_unmapped();
		sc_clock_enable();
		end_of_test();
	end
endmodule
